/* hw/pss_sequencer.sv */
/*
 * Start-up safety check sequencer of a multi-cell battery protector.
 * Holds both gate drives off and forces the recovery margin selects
 * until start-up completes, samples the cell and discharge comparators
 * once at the sample point, and enters a protection state on fault.
 * Assumes all inputs synchronous to CLOCK_I and comparators outside.
 */
//
// Overview of operation
// - Start-up check begins only after the digital reset is released.
// - Both gate drives held low while start-up is incomplete.
// - Low-cell recovery margin select forced high until start-up completes.
// - High-cell recovery margin select forced high until start-up completes.
// - One safety sample pulse at 50 ms, four comparators, filters bypassed.
// - Any fault seen at the sample sets the internal fault status bit.
// - A further 50 ms lets a corrupted sample recover.
// - At 100 ms start-up completes; with no fault, outputs go normal.
// - A start-up fault enters the matching protection state instead.
// - Charge-short, temperature, thermistor, overcurrent checks only after start-up.
// - The check runs after power-on reset or digital reset.
// - The check repeats on recovery from shutdown after charger detection.
// - System undervoltage turns both gates off within 500 us.
// - Gates driven low when either drive reservoir is below threshold.
// - Supply lockout high holds start-up sequencing off.
// - Charger present triggers the recovery start-up from shutdown.
module pss_sequencer #(
	parameter int unsigned SAMPLE_CYC = pss_pkg::SAMPLE_CYC,
	parameter int unsigned DONE_CYC = pss_pkg::DONE_CYC
) (
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	input wire logic SUPPLY_LOCKOUT_I,
	input wire logic CHARGER_PRESENT_I,
	input wire logic SHUTDOWN_I,
	input wire logic SYS_UNDERVOLTAGE_I,
	input wire logic CHARGE_RESERVOIR_LOW_I,
	input wire logic DISCHARGE_RESERVOIR_LOW_I,
	input wire pss_pkg::pss_cmp_t CMP_RAW_I,
	input wire pss_pkg::pss_late_t LATE_RAW_I,
	input wire pss_pkg::pss_drive_t NORMAL_DRIVE_I,
	output pss_pkg::pss_drive_t DRIVE_O,
	output logic SAFETY_SAMPLE_PULSE_O,
	output logic STARTUP_COMPLETE_O,
	output logic FAULT_STATUS_O,
	output pss_pkg::pss_prot_t PROT_STATE_O,
	output pss_pkg::pss_late_t LATE_FAULT_O
);

	typedef struct packed {
		pss_pkg::pss_state_t state;
		logic [pss_pkg::CNT_W-1:0] cnt;
		logic pulse;
		logic fault;
		pss_pkg::pss_cmp_t seen;
		pss_pkg::pss_prot_t prot;
		pss_pkg::pss_drive_t drive;
		pss_pkg::pss_late_t late;
		logic shut_seen;
	} pss_st_t;

	localparam logic [pss_pkg::CNT_W-1:0] SAMPLE_AT = pss_pkg::CNT_W'(SAMPLE_CYC);
	localparam logic [pss_pkg::CNT_W-1:0] DONE_AT = pss_pkg::CNT_W'(DONE_CYC);

	pss_st_t st;
	pss_st_t next_st;
	logic kill;
	pss_pkg::pss_prot_t sample_prot;
	logic restart;

	// Gate collapse shutoff path
	pss_gate_kill u_kill (
		.clk_i(CLOCK_I),
		.rst_n_i(RST_N_I),
		.sys_uv_i(SYS_UNDERVOLTAGE_I),
		.chg_res_low_i(CHARGE_RESERVOIR_LOW_I),
		.dsg_res_low_i(DISCHARGE_RESERVOIR_LOW_I),
		.kill_o(kill)
	);

	// Protection state matching the sampled fault, lowest cell first
	always_comb begin
		if (st.seen.cell_low_voltage) begin
			sample_prot = pss_pkg::PSS_PROT_CELL_LOW;
		end else if (st.seen.cell_high_voltage) begin
			sample_prot = pss_pkg::PSS_PROT_CELL_HIGH;
		end else if (st.seen.discharge_short) begin
			sample_prot = pss_pkg::PSS_PROT_DSG_SHORT;
		end else if (st.seen.discharge_overcurrent) begin
			sample_prot = pss_pkg::PSS_PROT_DSG_OC;
		end else begin
			sample_prot = pss_pkg::PSS_PROT_NONE;
		end
	end

	// Recovery start when a charger appears after a shutdown
	// repeat on charger recovery
	assign restart = st.shut_seen & CHARGER_PRESENT_I & ~SHUTDOWN_I;

	// Sequencer next state
	always_comb begin
		next_st = st;
		next_st.pulse = 1'b0;
		if (SHUTDOWN_I) begin
			next_st.shut_seen = 1'b1;
		end
		case (st.state)
			pss_pkg::PSS_IDLE: begin
				next_st.cnt = pss_pkg::CNT_RST;
				if (!SUPPLY_LOCKOUT_I) begin
					next_st.state = pss_pkg::PSS_RUN;
					next_st.fault = 1'b0;
					next_st.seen = '0;
					next_st.prot = pss_pkg::PSS_PROT_NONE;
				end
			end
			pss_pkg::PSS_RUN: begin
				next_st.cnt = st.cnt + 1'b1;
				if (st.cnt == SAMPLE_AT - 1'b1) begin
					next_st.pulse = 1'b1;
				end
				if (st.pulse) begin
					next_st.seen = CMP_RAW_I;
					next_st.fault = |CMP_RAW_I;
				end
				if (st.cnt == DONE_AT - 1'b1) begin
					next_st.state = pss_pkg::PSS_DONE;
					next_st.prot = sample_prot;
				end
			end
			pss_pkg::PSS_DONE: begin
				next_st.cnt = st.cnt;
				next_st.late = LATE_RAW_I;
				if (restart) begin
					next_st.state = pss_pkg::PSS_IDLE;
					next_st.shut_seen = 1'b0;
				end
			end
			default: begin
				next_st.state = pss_pkg::PSS_IDLE;
			end
		endcase
		// Late checks stay zero unless start-up is complete in the next cycle too
		if (next_st.state != pss_pkg::PSS_DONE) begin
			next_st.late = '0;
		end
		// Output drives
		if (st.state != pss_pkg::PSS_DONE || next_st.state != pss_pkg::PSS_DONE) begin
			next_st.drive.charge_gate_drive = 1'b0;
			next_st.drive.discharge_gate_drive = 1'b0;
			next_st.drive.low_cell_recovery_margin_sel = 1'b1;
			next_st.drive.high_cell_recovery_margin_sel = 1'b1;
		end else if (st.prot == pss_pkg::PSS_PROT_NONE) begin
			next_st.drive = NORMAL_DRIVE_I;
		end else begin
			// Protection state: gates off, both margin selects held high until a restart
			next_st.drive.charge_gate_drive = 1'b0;
			next_st.drive.discharge_gate_drive = 1'b0;
			next_st.drive.low_cell_recovery_margin_sel = 1'b1;
			next_st.drive.high_cell_recovery_margin_sel = 1'b1;
		end
		if (kill) begin
			next_st.drive.charge_gate_drive = 1'b0;
			next_st.drive.discharge_gate_drive = 1'b0;
		end
	end

	// State register; reset restarts the whole check
	always_ff @(posedge CLOCK_I) begin
		if (!RST_N_I) begin
			st.state <= pss_pkg::PSS_IDLE;
			st.cnt <= pss_pkg::CNT_RST;
			st.pulse <= 1'b0;
			st.fault <= 1'b0;
			st.seen <= '0;
			st.prot <= pss_pkg::PSS_PROT_NONE;
			st.drive <= 4'h3;
			st.late <= '0;
			st.shut_seen <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign DRIVE_O = st.drive;
	assign SAFETY_SAMPLE_PULSE_O = st.pulse;
	assign STARTUP_COMPLETE_O = (st.state == pss_pkg::PSS_DONE);
	assign FAULT_STATUS_O = st.fault;
	assign PROT_STATE_O = st.prot;
	assign LATE_FAULT_O = st.late;

	// Assertion helpers
	logic gate_any;
	assign gate_any = st.drive.charge_gate_drive | st.drive.discharge_gate_drive;

	sequence s_pulse;
		SAFETY_SAMPLE_PULSE_O;
	endsequence

	sequence s_sample_taken;
		s_pulse ##1 (FAULT_STATUS_O == |$past(CMP_RAW_I));
	endsequence

	a_gates_off_early: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		!STARTUP_COMPLETE_O |-> !gate_any)
		else $error("gate drive on before start-up complete");

	a_low_margin_forced: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		!STARTUP_COMPLETE_O |-> DRIVE_O.low_cell_recovery_margin_sel)
		else $error("low-cell margin not forced");

	a_high_margin_forced: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		!STARTUP_COMPLETE_O |-> DRIVE_O.high_cell_recovery_margin_sel)
		else $error("high-cell margin not forced");

	a_pulse_single: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		s_pulse |=> !SAFETY_SAMPLE_PULSE_O && st.cnt == SAMPLE_AT + 1'b1)
		else $error("sample pulse wrong length or time");

	a_fault_from_sample: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		s_pulse |-> s_sample_taken)
		else $error("fault status not taken from sample");

	a_done_at_count: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		$rose(STARTUP_COMPLETE_O) |-> st.cnt == DONE_AT)
		else $error("start-up complete at wrong count");

	a_prot_on_fault: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		$rose(STARTUP_COMPLETE_O) && FAULT_STATUS_O |-> PROT_STATE_O != pss_pkg::PSS_PROT_NONE ##1 !gate_any)
		else $error("fault did not enter protection");

	a_late_masked: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		!STARTUP_COMPLETE_O |-> LATE_FAULT_O == '0)
		else $error("late check seen during start-up");

	a_uv_shutoff: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		SYS_UNDERVOLTAGE_I |-> ##[1:3] !gate_any)
		else $error("gates not off after undervoltage");

	a_lockout_hold: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		SUPPLY_LOCKOUT_I && st.state == pss_pkg::PSS_IDLE |=> st.state == pss_pkg::PSS_IDLE)
		else $error("sequence started under lockout");

	a_fault_cleared: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		st.state == pss_pkg::PSS_IDLE && !SUPPLY_LOCKOUT_I |=> !FAULT_STATUS_O)
		else $error("fault not cleared at new sequence");

	// Sequence start and counter placement
	a_run_from_zero: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		st.state == pss_pkg::PSS_IDLE && !SUPPLY_LOCKOUT_I |=> st.state == pss_pkg::PSS_RUN && st.cnt == pss_pkg::CNT_RST)
		else $error("run did not start from a cleared counter");

	a_count_steps: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		st.state == pss_pkg::PSS_RUN |=> st.cnt == $past(st.cnt) + 1'b1)
		else $error("start-up counter did not advance");

	a_pulse_at_sample: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		SAFETY_SAMPLE_PULSE_O |-> st.state == pss_pkg::PSS_RUN && st.cnt == SAMPLE_AT)
		else $error("sample pulse outside the sample point");

	a_recovery_window: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		st.state == pss_pkg::PSS_RUN && st.cnt < DONE_AT - 1'b1 |=> !STARTUP_COMPLETE_O)
		else $error("start-up completed inside the recovery window");

	// Completion and the outputs that follow it
	a_done_holds: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		STARTUP_COMPLETE_O && !restart |=> STARTUP_COMPLETE_O)
		else $error("start-up complete dropped without restart");

	a_normal_drive: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		$rose(STARTUP_COMPLETE_O) && PROT_STATE_O == pss_pkg::PSS_PROT_NONE && !kill && !restart
		|=> DRIVE_O == $past(NORMAL_DRIVE_I))
		else $error("normal drive not taken after clean start-up");

	a_clean_no_prot: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		$rose(STARTUP_COMPLETE_O) && !FAULT_STATUS_O |-> PROT_STATE_O == pss_pkg::PSS_PROT_NONE)
		else $error("protection entered without a fault");

	a_late_follows: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		STARTUP_COMPLETE_O && !restart |=> LATE_FAULT_O == $past(LATE_RAW_I))
		else $error("late checks not evaluated after start-up");

	// Shutoff and recovery paths
	a_reservoir_kill: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		CHARGE_RESERVOIR_LOW_I || DISCHARGE_RESERVOIR_LOW_I |-> ##2 !gate_any)
		else $error("gates not off after reservoir low");

	a_charger_restart: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
		STARTUP_COMPLETE_O && restart |=> st.state == pss_pkg::PSS_IDLE && !STARTUP_COMPLETE_O)
		else $error("charger recovery did not restart the check");

endmodule

/* hw/pss_pkg.sv */
/*
 * Package for the start-up safety check sequencer: timing constants,
 * sequencer states and the grouped comparator and gate-drive carriers.
 * Assumes a single 20 MHz internal clock.
 */
package pss_pkg;

	// Clock rate in kHz
	localparam int unsigned CLK_KHZ = 20_000;
	// Sample point and completion point, in milliseconds
	localparam int unsigned SAMPLE_MS = 50;
	localparam int unsigned DONE_MS = 100;
	// Forced shutoff bound on system undervoltage, in microseconds
	localparam int unsigned SYS_UV_OFF_US = 500;
	// Derived cycle counts
	localparam int unsigned SAMPLE_CYC = SAMPLE_MS * CLK_KHZ;
	localparam int unsigned DONE_CYC = DONE_MS * CLK_KHZ;
	localparam int unsigned SYS_UV_OFF_CYC = (SYS_UV_OFF_US * CLK_KHZ) / 1000;
	// Counter width, covers the completion count
	localparam int unsigned CNT_W = 22;
	// Reset value of the start-up counter, which holds its value once start-up completes
	localparam logic [CNT_W-1:0] CNT_RST = 22'h00_0000;

	// Sequencer states
	typedef enum logic [1:0] {
		PSS_IDLE = 2'b00,
		PSS_RUN = 2'b01,
		PSS_DONE = 2'b10
	} pss_state_t;

	// Comparator outputs seen at the sample point
	typedef struct packed {
		logic cell_low_voltage;
		logic cell_high_voltage;
		logic discharge_overcurrent;
		logic discharge_short;
	} pss_cmp_t;

	// Post start-up checks, not sampled during start-up
	typedef struct packed {
		logic charge_short;
		logic over_temperature;
		logic thermistor_fault;
		logic over_current;
	} pss_late_t;

	// Gate-drive and hysteresis-select outputs
	typedef struct packed {
		logic charge_gate_drive;
		logic discharge_gate_drive;
		logic low_cell_recovery_margin_sel;
		logic high_cell_recovery_margin_sel;
	} pss_drive_t;

	// Protection state entered after start-up
	typedef enum logic [2:0] {
		PSS_PROT_NONE = 3'b000,
		PSS_PROT_CELL_LOW = 3'b001,
		PSS_PROT_CELL_HIGH = 3'b010,
		PSS_PROT_DSG_OC = 3'b011,
		PSS_PROT_DSG_SHORT = 3'b100
	} pss_prot_t;

endpackage

/* hw/pss_gate_kill.sv */
/*
 * Fast forced gate shutoff: on system undervoltage or a low gate-drive
 * reservoir, asserts a kill level that forces both gates off.
 * Assumes inputs are synchronous to the internal clock.
 */
module pss_gate_kill (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic sys_uv_i,
	input wire logic chg_res_low_i,
	input wire logic dsg_res_low_i,
	output logic kill_o
);

	typedef struct packed {
		logic kill;
	} pss_kill_st_t;

	pss_kill_st_t st;
	pss_kill_st_t next_st;

	// Kill follows any collapse condition within one cycle
	always_comb begin
		next_st = st;
		next_st.kill = sys_uv_i | chg_res_low_i | dsg_res_low_i;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign kill_o = st.kill;

endmodule

/* sim/pss_fet_gates.sv */
/*
 * Behavioural model of the external charge and discharge FET gates.
 * Assumes the gate drive comes from the sequencer; one clock of switching lag.
 */
module pss_fet_gates (
	input wire logic clk_i,
	input wire pss_pkg::pss_drive_t drive_i,
	output logic chg_fet_on_o,
	output logic dsg_fet_on_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Gate charge follows the drive one clock later
	always_ff @(posedge clk_i) begin
		chg_fet_on_o <= drive_i.charge_gate_drive;
		dsg_fet_on_o <= drive_i.discharge_gate_drive;
	end
endmodule

/* sim/powerup_safety_check_sequencer_bench.sv */
/*
 * Self-checking bench for the start-up safety check sequencer.
 * Assumes shortened sample and completion counts; inputs driven at the falling edge.
 */
module powerup_safety_check_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned S_CYC = 20;
	localparam int unsigned D_CYC = 40;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic lockout = 1'b0;
	logic charger = 1'b0;
	logic shutdown = 1'b0;
	logic sys_uv = 1'b0;
	logic chg_low = 1'b0;
	logic dsg_low = 1'b0;
	pss_pkg::pss_cmp_t cmp = '0;
	pss_pkg::pss_late_t late = '0;
	pss_pkg::pss_drive_t normal = '0;
	pss_pkg::pss_drive_t drive;
	pss_pkg::pss_late_t late_out;
	pss_pkg::pss_prot_t prot;
	logic pulse, done, fault, chg_on, dsg_on;
	int err_count = 0;
	int n_checks = 0;
	int seed = 53;
	int i;

	// Free-running clock, 50 ns period
	always #25 clk = ~clk;

	pss_sequencer #(.SAMPLE_CYC(S_CYC), .DONE_CYC(D_CYC)) dut_u (.CLOCK_I(clk), .RST_N_I(rst_n),
		.SUPPLY_LOCKOUT_I(lockout), .CHARGER_PRESENT_I(charger), .SHUTDOWN_I(shutdown),
		.SYS_UNDERVOLTAGE_I(sys_uv), .CHARGE_RESERVOIR_LOW_I(chg_low), .DISCHARGE_RESERVOIR_LOW_I(dsg_low),
		.CMP_RAW_I(cmp), .LATE_RAW_I(late), .NORMAL_DRIVE_I(normal), .DRIVE_O(drive),
		.SAFETY_SAMPLE_PULSE_O(pulse), .STARTUP_COMPLETE_O(done), .FAULT_STATUS_O(fault),
		.PROT_STATE_O(prot), .LATE_FAULT_O(late_out));
	pss_fet_gates fet_u (.clk_i(clk), .drive_i(drive), .chg_fet_on_o(chg_on), .dsg_fet_on_o(dsg_on));

	// Compare tasks, one per kind of result
	task automatic check1(string name, logic exp, logic got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic checkv(string name, logic [7:0] exp, logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic check_prot(string name, pss_pkg::pss_prot_t exp, pss_pkg::pss_prot_t got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %0d seen %0d", name, exp, got);
		end
	endtask

	// Expected protection state by fault priority
	function automatic pss_pkg::pss_prot_t exp_prot(pss_pkg::pss_cmp_t c);
		if (c.cell_low_voltage) return pss_pkg::PSS_PROT_CELL_LOW;
		if (c.cell_high_voltage) return pss_pkg::PSS_PROT_CELL_HIGH;
		if (c.discharge_short) return pss_pkg::PSS_PROT_DSG_SHORT;
		if (c.discharge_overcurrent) return pss_pkg::PSS_PROT_DSG_OC;
		return pss_pkg::PSS_PROT_NONE;
	endfunction

	// Verdict and end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// Digital reset held for 8 clocks
	task automatic do_reset();
		@(negedge clk);
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
	endtask

	// One start-up sequence with the current comparator value at the sample
	task automatic run_seq(string tname);
		pss_pkg::pss_cmp_t sampled;
		int n;
		sampled = cmp;
		n = 0;
		while (pulse !== 1'b1) begin
			checkv("drive before sample", 8'h03, 8'(drive));
			check1("complete early", 1'b0, done);
			check1("fault carried over", 1'b0, fault);
			@(negedge clk);
			n++;
			if (n > 100) begin
				err_count++;
				summarize();
			end
		end
		checkv("late before done", 8'h00, 8'(late_out));
		@(negedge clk);
		check1("pulse width", 1'b0, pulse);
		check1("fault status", |sampled, fault);
		cmp = pss_pkg::pss_cmp_t'(4'($random(seed)));
		n = 1;
		while (done !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (done !== 1'b1) begin
			err_count++;
			summarize();
		end
		checkv("sample to done", 8'(D_CYC - S_CYC), 8'(n));
		check_prot("prot state", exp_prot(sampled), prot);
		checkv("drive at done", 8'h03, 8'(drive));
		@(negedge clk);
		checkv("drive after done", (|sampled) ? 8'h03 : 8'(normal), 8'(drive));
		checkv("late after done", 8'(late), 8'(late_out));
		$display("test %s finished", tname);
	endtask

	// Main sequence
	initial begin
		for (i = 0; i < 8; i++) begin
			cmp = (i < 4) ? pss_pkg::pss_cmp_t'(4'(1 << i)) : pss_pkg::pss_cmp_t'(4'((i == 4) ? 0 : $random(seed)));
			late = pss_pkg::pss_late_t'(4'($random(seed)));
			normal = pss_pkg::pss_drive_t'(4'($random(seed)));
			do_reset();
			run_seq("reset sample");
		end
		cmp = pss_pkg::pss_cmp_t'(4'hF);
		do_reset();
		run_seq("fault before restart");
		shutdown = 1'b1;
		@(negedge clk);
		shutdown = 1'b0;
		charger = 1'b1;
		repeat (2) @(negedge clk);
		charger = 1'b0;
		cmp = '0;
		run_seq("charger restart");
		lockout = 1'b1;
		do_reset();
		repeat (60) begin
			@(negedge clk);
			check1("pulse in lockout", 1'b0, pulse);
		end
		lockout = 1'b0;
		run_seq("after lockout");
		for (i = 0; i < 3; i++) begin
			cmp = '0;
			normal = pss_pkg::pss_drive_t'(4'hC);
			do_reset();
			run_seq("kill setup");
			{sys_uv, chg_low, dsg_low} = 3'(1 << i);
			repeat (3) @(negedge clk);
			checkv("gates on kill", 8'h00, {6'h00, drive.charge_gate_drive, drive.discharge_gate_drive});
			@(negedge clk);
			checkv("fets on kill", 8'h00, {6'h00, chg_on, dsg_on});
			{sys_uv, chg_low, dsg_low} = 3'h0;
			$display("test kill source %0d finished", i);
		end
		summarize();
	end
endmodule
